// File: imui_cfg.svh
// Constants for the interrupt mask and request unit
`ifndef IMUI_CFG_SVH
`define IMUI_CFG_SVH
`define IMUI_MASK_RESET 8'h00
`define IMUI_REQ_RESET 6'h00
`define IMUI_MASK_VALID 8'hbf
`define IMUI_GLOBAL_BIT 7
`define IMUI_NUM_LEVELS 6
`define IMUI_VEC_BASE 8'h02
`define IMUI_SRC_UNCOND 6'h3f
`define IMUI_EXT_FALL_A_LVL 1
`define IMUI_EXT_FALL_B_LVL 3
`define IMUI_EXT_RISE_A_LVL 4
`endif

// File: imui_pkg.sv
// Types shared by the interrupt mask and request unit
package imui_pkg;
    typedef logic [5:0] imui_lvl_t;
    typedef logic [2:0] imui_idx_t;
endpackage

// File: imui_edge_if.sv
// Edge events from a pin detector to the request logic
`timescale 1ns/1ps
`default_nettype none
interface imui_edge_if;
    logic rise;
    logic fall;
    modport src (output rise, output fall);
    modport dst (input rise, input fall);
endinterface
`default_nettype wire

// File: imui_edge_det.sv
// Synchronised edge detector for one external request pin
`timescale 1ns/1ps
`default_nettype none
module imui_edge_det
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_pin,
    imui_edge_if.src edge_o
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic [2:0] valid_reg;

    // Valid shift keeps a pin that sits high at reset from looking like a rising edge
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
            valid_reg <= 3'h0;
        end
        else
        begin
            sync1_reg <= i_pin;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
            valid_reg <= {valid_reg[1:0], 1'b1};
        end
    end

    assign edge_o.rise = valid_reg[2] & sync2_reg & ~prev_reg;
    assign edge_o.fall = valid_reg[2] & ~sync2_reg & prev_reg;
endmodule
`default_nettype wire

// File: imui_top.sv
// Interrupt mask and request unit: request flags, mask, priority and vector
//
// Behaviour
// - Mask bits 0 to 5 each enable the request level of the same number; a level with a 0 bit is never taken.
// - Mask bit 7 is the global enable; with it clear no request is taken at all.
// - The global-on instruction sets bit 7 and the global-off instruction clears it.
// - Taking an interrupt clears bit 7, and the return-from-service instruction sets it again.
// - Reset clears both the mask and the request flags.
// - Software may write the request flags at any time and such a request is masked and serviced like a hardware one.
// - A request is taken only with global and level enable set and no higher enabled request pending, through its vector.
// - A software write to the request flags wins, and a hardware set in the same cycle is lost.
// - Some internal sources always set their flag while others set it only when configured to.
// - Once the global enable is set inside a service routine, a higher enabled request may interrupt it.
// - Six levels with level 0 highest; level n vectors to location 2+2n, from 2,3 up to C,D.
// - External sources set their flag on one pin transition: pin A falling sets level 1, pin B falling level 3, pin A rising level 4.
`timescale 1ns/1ps
`default_nettype none
`include "imui_cfg.svh"
module imui_top
    import imui_pkg::*;
#(
    parameter int NUM_LEVELS = `IMUI_NUM_LEVELS,
    parameter imui_lvl_t SRC_UNCOND = `IMUI_SRC_UNCOND
)
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_mask_wr,
    input wire logic i_req_wr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_mask_rdata,
    output logic [7:0] o_req_rdata,
    input wire logic i_global_on_op,
    input wire logic i_global_off_op,
    input wire logic i_return_from_service_op,
    input wire logic i_ack,
    output logic o_irq_pending,
    output logic [7:0] o_vector,
    input wire logic [5:0] i_periph_event,
    input wire logic [5:0] i_periph_arm,
    input wire logic i_pin_a,
    input wire logic i_pin_b
);
    generate
        if (NUM_LEVELS != 6)
        begin : g_bad_levels
            $error("imui_top serves exactly six request levels");
        end
    endgenerate

    // Lowest set index wins: level 0 is the highest priority
    function automatic imui_idx_t imui_pick(input imui_lvl_t v);
        imui_idx_t idx;
        idx = 3'h0;
        for (int i = 5; i >= 0; i--)
        begin
            if (v[i])
            begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    function automatic imui_lvl_t imui_onehot(input imui_idx_t idx);
        return imui_lvl_t'(6'h01 << idx);
    endfunction

    imui_edge_if edge_a ();
    imui_edge_if edge_b ();

    imui_edge_det u_edge_a
    (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_pin(i_pin_a),
        .edge_o(edge_a)
    );

    imui_edge_det u_edge_b
    (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_pin(i_pin_b),
        .edge_o(edge_b)
    );

    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    imui_lvl_t req_reg;
    imui_lvl_t req_next;
    logic irq_reg;
    imui_idx_t level_reg;
    logic [7:0] vector_reg;
    imui_lvl_t sel_reg;

    wire imui_lvl_t ext_set = imui_onehot(3'(`IMUI_EXT_FALL_A_LVL)) & {6{edge_a.fall}}
                            | imui_onehot(3'(`IMUI_EXT_FALL_B_LVL)) & {6{edge_b.fall}}
                            | imui_onehot(3'(`IMUI_EXT_RISE_A_LVL)) & {6{edge_a.rise}};
    wire imui_lvl_t periph_set = i_periph_event & (SRC_UNCOND | i_periph_arm);
    wire imui_lvl_t hw_set = ext_set | periph_set;
    wire logic global_en = mask_reg[`IMUI_GLOBAL_BIT];
    // Selection follows the live mask, so re-enabling inside a routine lets a higher level in
    wire imui_lvl_t sel_vec = req_reg & mask_reg[5:0] & {6{global_en}};
    wire logic sel_any = |sel_vec;
    wire imui_idx_t sel_idx = imui_pick(sel_vec);
    wire logic taken = i_ack & irq_reg;
    wire imui_lvl_t ack_clr = taken ? imui_onehot(level_reg) : 6'h00;

    // Hardware set wins over the acknowledge clear; a software write wins over both
    assign req_next = i_req_wr ? i_wdata[5:0] : ((req_reg & ~ack_clr) | hw_set);

    always_comb
    begin
        mask_next = mask_reg;
        if (i_mask_wr)
        begin
            mask_next = i_wdata & `IMUI_MASK_VALID;
        end
        else if (taken)
        begin
            mask_next[`IMUI_GLOBAL_BIT] = 1'b0;
        end
        else if (i_global_on_op | i_return_from_service_op)
        begin
            mask_next[`IMUI_GLOBAL_BIT] = 1'b1;
        end
        else if (i_global_off_op)
        begin
            mask_next[`IMUI_GLOBAL_BIT] = 1'b0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            mask_reg <= `IMUI_MASK_RESET;
            req_reg <= `IMUI_REQ_RESET;
            irq_reg <= 1'b0;
            level_reg <= 3'h0;
            vector_reg <= `IMUI_VEC_BASE;
            sel_reg <= 6'h00;
        end
        else
        begin
            mask_reg <= mask_next;
            req_reg <= req_next;
            // Drop the request in the acknowledge cycle so it is not taken twice
            irq_reg <= sel_any & ~taken;
            level_reg <= sel_idx;
            vector_reg <= `IMUI_VEC_BASE + {4'h0, sel_idx, 1'b0};
            sel_reg <= sel_vec;
        end
    end

    assign o_mask_rdata = mask_reg;
    assign o_req_rdata = {2'b00, req_reg};
    assign o_irq_pending = irq_reg;
    assign o_vector = vector_reg;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    property p_level_gate;
        (mask_reg[5:0] == 6'h00) && !i_mask_wr |=> !irq_reg;
    endproperty
    a_level_gate: assert property (p_level_gate) else $error("request taken with all levels masked");

    property p_global_gate;
        !global_en |=> !irq_reg;
    endproperty
    a_global_gate: assert property (p_global_gate) else $error("request taken with global enable clear");

    property p_global_ops;
        !i_mask_wr && !taken |->
            (i_global_on_op |=> global_en) and
            (i_global_off_op && !i_global_on_op && !i_return_from_service_op |=> !global_en);
    endproperty
    a_global_ops: assert property (p_global_ops) else $error("global enable missed an instruction");

    sequence s_entry;
        taken && !i_mask_wr;
    endsequence
    sequence s_return;
        i_return_from_service_op && !i_mask_wr && !taken;
    endsequence
    property p_entry_return;
        (s_entry |=> !global_en && !irq_reg) and (s_return |=> global_en);
    endproperty
    a_entry_return: assert property (p_entry_return) else $error("global enable wrong at entry or return");

    property p_reset_clear;
        disable iff (1'b0) i_reset |=> (mask_reg == 8'h00) && (req_reg == 6'h00) && !irq_reg;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("registers not cleared by reset");

    property p_soft_write;
        i_req_wr |=> o_req_rdata == {2'b00, $past(i_wdata[5:0])};
    endproperty
    a_soft_write: assert property (p_soft_write) else $error("request write not stored");

    property p_priority;
        irq_reg |-> sel_reg[level_reg] &&
            ((sel_reg & imui_lvl_t'(imui_onehot(level_reg) - 6'h01)) == 6'h00) &&
            (o_vector == `IMUI_VEC_BASE + {4'h0, level_reg, 1'b0});
    endproperty
    a_priority: assert property (p_priority) else $error("wrong level or vector selected");

    property p_soft_wins;
        i_req_wr |=> (req_reg & $past(hw_set & ~i_wdata[5:0])) == 6'h00;
    endproperty
    a_soft_wins: assert property (p_soft_wins) else $error("hardware set survived a software write");

    property p_hw_set;
        !i_req_wr |=> (req_reg & $past(hw_set)) == $past(hw_set);
    endproperty
    a_hw_set: assert property (p_hw_set) else $error("hardware event did not set its flag");

    property p_ack_clear;
        taken && !i_req_wr && !hw_set[level_reg] |=> !req_reg[$past(level_reg)];
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("acknowledged flag not cleared");
endmodule
`default_nettype wire

// File: imui_core_model.sv
// Processor core model that takes offered interrupts
`timescale 1ns/1ps
`default_nettype none
module imui_core_model
(
    input wire logic i_clk,
    input wire logic i_auto,
    input wire logic i_slow,
    input wire logic i_pend,
    input wire logic [7:0] i_vec,
    output logic o_ack,
    output logic [7:0] o_vec
);
    int wait_cnt = 0;
    initial o_ack = 1'b0;
    initial o_vec = 8'h00;
    // Slow mode stands off a few cycles, as a core finishing an instruction would
    always @(posedge i_clk)
    begin
        o_ack <= 1'b0;
        if (o_ack && i_pend)
            o_vec <= i_vec;
        if (!i_auto || !i_pend || o_ack)
            wait_cnt <= 0;
        else if (wait_cnt >= (i_slow ? 3 : 0))
            o_ack <= 1'b1;
        else
            wait_cnt <= wait_cnt + 1;
    end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the interrupt mask and request unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import imui_pkg::*;
    logic clk, ack, pend;
    logic rst = 1, mwr = 0, rwr = 0, on = 0, off = 0, ret = 0, pa = 1, pb = 1, auto = 1, slow = 0;
    logic [7:0] wd = 8'h00;
    logic [7:0] mrd, rrd, vec, cvec;
    logic [5:0] ev = 6'h00;
    logic [5:0] arm = 6'h00;
    int n_mismatch = 0;
    int tests_run = 0;
    // Level 0 made conditional so the arm input is exercised
    imui_top #(.SRC_UNCOND(6'h3e)) dut (.i_clk(clk), .i_reset(rst), .i_mask_wr(mwr), .i_req_wr(rwr),
        .i_wdata(wd), .o_mask_rdata(mrd), .o_req_rdata(rrd), .i_global_on_op(on), .i_global_off_op(off),
        .i_return_from_service_op(ret), .i_ack(ack), .o_irq_pending(pend), .o_vector(vec),
        .i_periph_event(ev), .i_periph_arm(arm), .i_pin_a(pa), .i_pin_b(pb));
    imui_core_model core (.i_clk(clk), .i_auto(auto), .i_slow(slow), .i_pend(pend), .i_vec(vec),
        .o_ack(ack), .o_vec(cvec));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic m, input logic [7:0] d);
        mwr = m;
        rwr = !m;
        wd = d;
        step();
        mwr = 0;
        rwr = 0;
        step();
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        step();
        s = 0;
        step();
    endtask
    task automatic take(input logic [7:0] v);
        int i;
        for (i = 0; i < 20 && pend !== 1'b1; i++)
            step();
        chk("vector", vec, v);
        for (i = 0; i < 20 && pend !== 1'b0; i++)
            step();
        chk("taken", cvec, v);
    endtask
    // Pins are left where the previous scenario put them, so a false edge after release would show up
    task automatic t_reset(input int n);
        rst = 1;
        step(n);
        rst = 0;
        chk("mask rst", mrd, 8'h00);
        chk("req rst", rrd, 8'h00);
        chk("vec rst", vec, 8'h02);
        step(8);
        chk("no edge", rrd, 8'h00);
        chk("idle", {7'h00, pend}, 8'h00);
    endtask
    task automatic t_levels;
        for (int l = 0; l < 6; l++)
        begin
            slow = l[0];
            wr(0, 8'h01 << l);
            wr(1, 8'h01 << l);
            pulse(on);
            take(8'h02 + 8'(2 * l));
            chk("req clr", rrd, 8'h00);
            chk("mask in", mrd, 8'h01 << l);
            pulse(ret);
            chk("mask ret", mrd, 8'h80 | (8'h01 << l));
            pulse(off);
            chk("mask off", mrd, 8'h01 << l);
        end
    endtask
    task automatic t_gate;
        wr(0, 8'h3f);
        wr(1, 8'h7f);
        chk("mask b6", mrd, 8'h3f);
        chk("gl off", {7'h00, pend}, 8'h00);
        wr(1, 8'hc0);
        chk("lvl off", {7'h00, pend}, 8'h00);
        wr(0, 8'h24);
        wr(1, 8'h24);
        // Core holds off, so the offer must stand until it is acknowledged
        auto = 0;
        pulse(on);
        step(5);
        chk("held", {7'h00, pend}, 8'h01);
        chk("held vec", vec, 8'h06);
        auto = 1;
        take(8'h06);
        wr(1, 8'h01);
        pulse(on);
        chk("nest idle", {7'h00, pend}, 8'h00);
        wr(0, 8'h21);
        take(8'h02);
        pulse(off);
        wr(1, 8'h24);
        pulse(ret);
        take(8'h0c);
        chk("req end", rrd, 8'h00);
    endtask
    task automatic t_hw;
        ev = 6'h01;
        step();
        ev = 6'h00;
        step();
        chk("cond", rrd, 8'h00);
        arm = 6'h01;
        ev = 6'h03;
        step();
        ev = 6'h00;
        step();
        chk("armed", rrd, 8'h03);
        // Written data has bit 2 clear, so only a lost hardware set leaves it clear
        wd = 8'h00;
        rwr = 1;
        ev = 6'h04;
        step();
        rwr = 0;
        ev = 6'h00;
        step();
        chk("sw wins", rrd, 8'h00);
        pb = 0;
        step(8);
        chk("pin b", rrd, 8'h08);
        pa = 0;
        step(8);
        chk("pin a f", rrd, 8'h0a);
        pa = 1;
        step(8);
        chk("pin a r", rrd, 8'h1a);
    endtask
    task automatic results;
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #100000;
        n_mismatch++;
        results();
    end
    initial
    begin
        t_reset(4);
        t_levels();
        t_gate();
        t_hw();
        t_reset(2);
        results();
    end
endmodule
`default_nettype wire
